// >>> core/bus_status_defines.svh
// Constants for the bus cycle status encoder and its bus controller
// Function
// - Two low-active status outputs mark cycle start
// - Cycle-start state while either status is low
// - Status outputs float during hold acknowledge
// - All four low encodes interrupt acknowledge
// - Single-low status with both selects low reserved
// - Both status high means no cycle start
// - Halt when address bit one high, else shutdown
// - Memory/io select high memory/halt, low io/intack
// - Code select separates fetch/data and intack/io
`ifndef BUS_STATUS_DEFINES_SVH
`define BUS_STATUS_DEFINES_SVH
// Status code layout: {codeIntack, memIo, statusHiN, statusLoN}
`define CS_WIDTH 4
`define CS_COD_BIT 3
`define CS_MIO_BIT 2
`define CS_HI_BIT 1
`define CS_LO_BIT 0
// Legal cycle codes, then the idle code
`define CS_INTACK 4'h0
`define CS_HALT_SHUT 4'h4
`define CS_MEM_READ 4'h5
`define CS_MEM_WRITE 4'h6
`define CS_IO_READ 4'h9
`define CS_IO_WRITE 4'hA
`define CS_CODE_READ 4'hD
`define CS_IDLE 4'hF
// Both status bits high: no cycle start
`define CS_NO_START 2'h3
// Address bit one value that marks a halt
`define HALT_A1 1'h1
// Level of a released (floating) pin, pulled up
`define PIN_RELEASED 1'h1
`endif

// >>> core/bus_status_pkg.sv
// Types and code helpers shared by both ends of the status bus
package bus_status_pkg;
`include "bus_status_defines.svh"

    typedef enum logic [3:0] {
        KIND_NONE,
        KIND_INTACK,
        KIND_HALT_SHUT,
        KIND_MEM_READ,
        KIND_MEM_WRITE,
        KIND_IO_READ,
        KIND_IO_WRITE,
        KIND_CODE_READ,
        KIND_RESERVED
    } cycle_kind_t;

    // Kind to pin code; illegal kinds give the idle code
    function automatic logic [`CS_WIDTH-1:0] encode_kind(input cycle_kind_t kind);
        case (kind)
            KIND_INTACK: encode_kind = `CS_INTACK;
            KIND_HALT_SHUT: encode_kind = `CS_HALT_SHUT;
            KIND_MEM_READ: encode_kind = `CS_MEM_READ;
            KIND_MEM_WRITE: encode_kind = `CS_MEM_WRITE;
            KIND_IO_READ: encode_kind = `CS_IO_READ;
            KIND_IO_WRITE: encode_kind = `CS_IO_WRITE;
            KIND_CODE_READ: encode_kind = `CS_CODE_READ;
            default: encode_kind = `CS_IDLE;
        endcase
    endfunction : encode_kind

    // Pin code to kind
    function automatic cycle_kind_t decode_code(input logic [`CS_WIDTH-1:0] code);
        case (code)
            `CS_INTACK: decode_code = KIND_INTACK;
            `CS_HALT_SHUT: decode_code = KIND_HALT_SHUT;
            `CS_MEM_READ: decode_code = KIND_MEM_READ;
            `CS_MEM_WRITE: decode_code = KIND_MEM_WRITE;
            `CS_IO_READ: decode_code = KIND_IO_READ;
            `CS_IO_WRITE: decode_code = KIND_IO_WRITE;
            `CS_CODE_READ: decode_code = KIND_CODE_READ;
            default: begin
                if (code[`CS_HI_BIT:`CS_LO_BIT] == `CS_NO_START) begin
                    decode_code = KIND_NONE;
                end else begin
                    decode_code = KIND_RESERVED;
                end
            end
        endcase
    endfunction : decode_code

endpackage : bus_status_pkg

// >>> core/bus_status_if.sv
// Status pins between the cycle status encoder and the bus controller
`timescale 1ns/1ps
interface bus_status_if;
    // Driven values and enables from the encoder
    logic statusHiOut;
    logic statusLoOut;
    logic memIoOut;
    logic codeIntackOut;
    logic addrOneOut;
    logic statusOe;
    logic selectOe;
    // Resolved wire levels; released pins pull high
    logic cycleStatusHiN;
    logic cycleStatusLoN;
    logic memIoSelect;
    logic codeIntackSelect;
    logic addressBitOne;

    // Wire resolution from the enables
    assign cycleStatusHiN = statusOe ? statusHiOut : 1'b1;
    assign cycleStatusLoN = statusOe ? statusLoOut : 1'b1;
    assign memIoSelect = selectOe ? memIoOut : 1'b1;
    assign codeIntackSelect = selectOe ? codeIntackOut : 1'b1;
    assign addressBitOne = selectOe ? addrOneOut : 1'b1;

    modport device_end (
        output statusHiOut,
        output statusLoOut,
        output memIoOut,
        output codeIntackOut,
        output addrOneOut,
        output statusOe,
        output selectOe
    );

    modport ctrl_end (
        input cycleStatusHiN,
        input cycleStatusLoN,
        input memIoSelect,
        input codeIntackSelect,
        input addressBitOne
    );
endinterface : bus_status_if

// >>> core/cycle_status_encoder.sv
// Device end: drives cycle status and selects at each cycle start
`timescale 1ns/1ps
`include "bus_status_defines.svh"
module cycle_status_encoder (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Status bus
    bus_status_if.device_end bus,
    // Cycle request from the core
    input wire logic cycleReq,
    input wire bus_status_pkg::cycle_kind_t cycleKind,
    input wire logic haltSelect,
    input wire logic cycleEnd,
    // Bus hold acknowledge
    input wire logic holdAck,
    // Request answer
    output logic reqReady,
    output logic reqRefused,
    // Cycle progress
    output logic cycleStartState,
    output logic cycleActive
);
    import bus_status_pkg::*;

    ////////////////////////////////////////////////////////////////
    // State and registers

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_ACTIVE
    } enc_state_t;

    // Cycle state
    enc_state_t state_q;
    enc_state_t state_d;
    // Pin values and their next values
    logic statusHi_q;
    logic statusHi_d;
    logic statusLo_q;
    logic statusLo_d;
    logic memIo_q;
    logic memIo_d;
    logic codeIntack_q;
    logic codeIntack_d;
    logic addrOne_q;
    logic addrOne_d;
    // Shared pin enable
    logic oe_q;
    logic oe_d;
    // Refusal pulse
    logic refused_q;
    logic refused_d;
    // Request decode
    logic [`CS_WIDTH-1:0] reqCode;
    logic reqLegal;
    logic idleReq;
    logic addrOneTake;
    logic take;

    ////////////////////////////////////////////////////////////////
    // Request decode

    // Code for the requested kind
    always_comb begin
        reqCode = encode_kind(cycleKind);
    end

    // True when a code pulls either status pin low; both high starts nothing
    function automatic logic has_start(input logic [`CS_WIDTH-1:0] code);
        has_start = (code[`CS_HI_BIT:`CS_LO_BIT] != `CS_NO_START);
    endfunction : has_start

    // Only kinds with a start code are legal, so reserved codes never leave
    always_comb begin
        reqLegal = has_start(reqCode);
    end

    // Ready only when idle and bus not held
    assign reqReady = (state_q == ST_IDLE) && !holdAck;

    // Request taken this edge
    assign take = cycleReq && reqReady && reqLegal;

    // Idle request, taken or not
    assign idleReq = cycleReq && (state_q == ST_IDLE);

    // Address bit one for a halt/shutdown take; other kinds keep the last value
    always_comb begin
        addrOneTake = addrOne_q;
        if (cycleKind == KIND_HALT_SHUT) begin
            addrOneTake = haltSelect ? `HALT_A1 : ~`HALT_A1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Cycle state machine

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d = ST_START;
                end
            end
            ST_START: begin
                state_d = ST_ACTIVE;
            end
            ST_ACTIVE: begin
                if (cycleEnd) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pin values

    // Next pin values; status idles high between start clocks
    always_comb begin
        statusHi_d = `PIN_RELEASED;
        statusLo_d = `PIN_RELEASED;
        memIo_d = memIo_q;
        codeIntack_d = codeIntack_q;
        addrOne_d = addrOne_q;
        if (take) begin
            // Status low for exactly the start clock
            statusHi_d = reqCode[`CS_HI_BIT];
            statusLo_d = reqCode[`CS_LO_BIT];
            memIo_d = reqCode[`CS_MIO_BIT];
            codeIntack_d = reqCode[`CS_COD_BIT];
            addrOne_d = addrOneTake;
        end
    end

    // Pin registers; status idles high after reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            statusHi_q <= `PIN_RELEASED;
            statusLo_q <= `PIN_RELEASED;
            memIo_q <= `PIN_RELEASED;
            codeIntack_q <= `PIN_RELEASED;
            addrOne_q <= `PIN_RELEASED;
        end else begin
            statusHi_q <= statusHi_d;
            statusLo_q <= statusLo_d;
            memIo_q <= memIo_d;
            codeIntack_q <= codeIntack_d;
            addrOne_q <= addrOne_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pin enable

    // Pins float from the edge after hold is acknowledged; a hold raised
    // in the start clock leaves a clean status, as the values idle high
    always_comb begin
        oe_d = !holdAck;
    end

    // Enable register; pins float through reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            oe_q <= 1'h0;
        end else begin
            oe_q <= oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Refusal

    // One pulse per idle request that is not taken
    always_comb begin
        refused_d = idleReq && !take;
    end

    // Refusal register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            refused_q <= 1'h0;
        end else begin
            refused_q <= refused_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs

    // Pins float whole while hold is acknowledged
    assign bus.statusHiOut = statusHi_q;
    assign bus.statusLoOut = statusLo_q;
    assign bus.memIoOut = memIo_q;
    assign bus.codeIntackOut = codeIntack_q;
    assign bus.addrOneOut = addrOne_q;
    assign bus.statusOe = oe_q;
    assign bus.selectOe = oe_q;

    // Progress flags
    assign cycleStartState = (state_q == ST_START);
    assign cycleActive = (state_q != ST_IDLE);
    assign reqRefused = refused_q;

endmodule : cycle_status_encoder

// >>> core/cycle_status_decoder.sv
// Bus controller end: decodes cycle status at each cycle start
`timescale 1ns/1ps
`include "bus_status_defines.svh"
module cycle_status_decoder (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Status bus
    bus_status_if.ctrl_end bus,
    // Decoded cycle
    output logic cycleStart,
    output bus_status_pkg::cycle_kind_t cycleKind,
    output logic haltCycle,
    output logic shutdownCycle,
    output logic reservedSeen,
    output logic inStartState
);
    import bus_status_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Decode

    logic [`CS_WIDTH-1:0] pinCode;
    cycle_kind_t kindNow;
    logic startNow;
    logic start_q;
    logic start_d;
    cycle_kind_t kind_q;
    cycle_kind_t kind_d;
    logic halt_q;
    logic halt_d;
    logic shut_q;
    logic shut_d;
    logic rsvd_q;
    logic rsvd_d;

    // Gather pins into a code
    assign pinCode = {bus.codeIntackSelect, bus.memIoSelect,
                      bus.cycleStatusHiN, bus.cycleStatusLoN};

    // Cycle start while either status is low
    assign startNow = !(bus.cycleStatusHiN && bus.cycleStatusLoN);
    assign kindNow = decode_code(pinCode);
    assign inStartState = startNow;

    // Next decoded values
    always_comb begin
        start_d = 1'b0;
        kind_d = kind_q;
        halt_d = 1'b0;
        shut_d = 1'b0;
        rsvd_d = 1'b0;
        if (startNow) begin
            if (kindNow == KIND_RESERVED) begin
                rsvd_d = 1'b1;
            end else begin
                start_d = 1'b1;
                kind_d = kindNow;
                if (kindNow == KIND_HALT_SHUT) begin
                    halt_d = (bus.addressBitOne == `HALT_A1);
                    shut_d = (bus.addressBitOne != `HALT_A1);
                end
            end
        end
    end

    // Decoded registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            start_q <= 1'b0;
            kind_q <= KIND_NONE;
            halt_q <= 1'b0;
            shut_q <= 1'b0;
            rsvd_q <= 1'b0;
        end else begin
            start_q <= start_d;
            kind_q <= kind_d;
            halt_q <= halt_d;
            shut_q <= shut_d;
            rsvd_q <= rsvd_d;
        end
    end

    assign cycleStart = start_q;
    assign cycleKind = kind_q;
    assign haltCycle = halt_q;
    assign shutdownCycle = shut_q;
    assign reservedSeen = rsvd_q;

endmodule : cycle_status_decoder

// >>> sim/bus_status_checker.sv
// Assertions on the status pins between the two ends
`timescale 1ns/1ps
module bus_status_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Enables and resolved pins
    input wire logic statusOe,
    input wire logic selectOe,
    input wire logic cycleStatusHiN,
    input wire logic cycleStatusLoN,
    input wire logic memIoSelect,
    input wire logic codeIntackSelect,
    input wire logic addressBitOne
);
    logic start;
    logic legal;
    logic [3:0] code;
    // Start clock, pin code and its legality
    assign start = !cycleStatusHiN || !cycleStatusLoN;
    assign code = {codeIntackSelect, memIoSelect, cycleStatusHiN, cycleStatusLoN};
    assign legal = code inside {4'h0, 4'h4, 4'h5, 4'h6, 4'h9, 4'hA, 4'hD};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Two quiet clocks after a start
    sequence quietSeq;
        (!start) [*2];
    endsequence
    a_start_one_clock: assert property (start |=> quietSeq)
        else $error("start clock too long");
    a_legal_code: assert property (start |-> legal)
        else $error("illegal start code");
    a_reserved_never: assert property (start && !codeIntackSelect && !memIoSelect
        |-> cycleStatusHiN == cycleStatusLoN)
        else $error("reserved code driven");
    a_intack_code: assert property (!cycleStatusHiN && !cycleStatusLoN && !memIoSelect
        |-> !codeIntackSelect)
        else $error("bad intack code");
    a_float_idle: assert property (!statusOe |-> !selectOe && code == 4'hF)
        else $error("pins driven in hold");
    a_code_fetch: assert property (start && codeIntackSelect && memIoSelect
        |-> !cycleStatusHiN && cycleStatusLoN)
        else $error("bad fetch code");
    a_io_select: assert property (start && !memIoSelect |-> code inside {4'h0, 4'h9, 4'hA})
        else $error("bad io code");
    a_select_hold: assert property (start
        |=> $stable({memIoSelect, codeIntackSelect, addressBitOne}) || !selectOe)
        else $error("selects moved");
endmodule : bus_status_checker

// >>> sim/bus_cycle_status_encoder_tb_top.sv
// Bench joining both ends, plus a decoder fed by the bench
`timescale 1ns/1ps
module bus_cycle_status_encoder_tb_top;
    import bus_status_pkg::*;
    logic core_clk, nrst, cycleReq, haltSelect, cycleEnd, holdAck;
    logic reqReady, reqRefused, startState, active, start, halt, shut, resv, inStart;
    logic start2, halt2, shut2, resv2, inStart2;
    logic [3:0] pins;
    cycle_kind_t reqKind, seenKind;
    int errors = 0;
    int cmpCount = 0;
    int cycles = 0;
    int seed;
    bus_status_if bus ();
    bus_status_if bus2 ();
    assign pins = {bus.codeIntackSelect, bus.memIoSelect, bus.cycleStatusHiN, bus.cycleStatusLoN};
    // Both ends across one interface
    cycle_status_encoder cycle_status_encoder_inst (.core_clk(core_clk), .nrst(nrst),
        .bus(bus), .cycleReq(cycleReq), .cycleKind(reqKind), .haltSelect(haltSelect),
        .cycleEnd(cycleEnd), .holdAck(holdAck), .reqReady(reqReady), .reqRefused(reqRefused),
        .cycleStartState(startState), .cycleActive(active));
    cycle_status_decoder cycle_status_decoder_inst (.core_clk(core_clk), .nrst(nrst),
        .bus(bus), .cycleStart(start), .cycleKind(seenKind), .haltCycle(halt),
        .shutdownCycle(shut), .reservedSeen(resv), .inStartState(inStart));
    // Decoder on pins driven by the bench
    cycle_status_decoder cycle_status_decoder_inst2 (.core_clk(core_clk), .nrst(nrst),
        .bus(bus2), .cycleStart(start2), .cycleKind(), .haltCycle(halt2),
        .shutdownCycle(shut2), .reservedSeen(resv2), .inStartState(inStart2));
    bus_status_checker bus_status_checker_inst (.core_clk(core_clk), .nrst(nrst),
        .statusOe(bus.statusOe), .selectOe(bus.selectOe), .cycleStatusHiN(bus.cycleStatusHiN),
        .cycleStatusLoN(bus.cycleStatusLoN), .memIoSelect(bus.memIoSelect),
        .codeIntackSelect(bus.codeIntackSelect), .addressBitOne(bus.addressBitOne));
    // Clock and hang limit
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            end_of_test();
        end
    end
    // Pin code expected for a kind
    function automatic logic [3:0] expCode(input cycle_kind_t k);
        case (k)
            KIND_INTACK: return 4'h0;
            KIND_HALT_SHUT: return 4'h4;
            KIND_MEM_READ: return 4'h5;
            KIND_MEM_WRITE: return 4'h6;
            KIND_IO_READ: return 4'h9;
            KIND_IO_WRITE: return 4'hA;
            KIND_CODE_READ: return 4'hD;
            default: return 4'hF;
        endcase
    endfunction : expCode
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("errors=%0d compares=%0d", errors, cmpCount);
        if (errors == 0 && cmpCount > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    // One whole bus cycle from request to end
    task automatic runCycle(input cycle_kind_t k, input logic h);
        logic hs;
        hs = (k == KIND_HALT_SHUT);
        @(negedge core_clk);
        cycleReq = 1'b1;
        reqKind = k;
        haltSelect = h;
        @(negedge core_clk);
        cycleReq = 1'b0;
        check({startState, active, inStart}, 3'h7);
        check(pins, expCode(k));
        if (hs) check(bus.addressBitOne, h);
        @(negedge core_clk);
        check({start, seenKind, halt, shut, resv}, {1'b1, k, hs && h, hs && !h, 1'b0});
        check(pins[1:0], 2'h3);
        cycleEnd = 1'b1;
        @(negedge core_clk);
        cycleEnd = 1'b0;
        check({reqReady, active}, 2'h2);
        check({startState, start, halt, shut}, 4'h0);
    endtask : runCycle
    // Request that must be turned away
    task automatic refuse(input cycle_kind_t k);
        @(negedge core_clk);
        cycleReq = 1'b1;
        reqKind = k;
        @(negedge core_clk);
        cycleReq = 1'b0;
        check({reqRefused, reqReady, bus.statusOe, pins[1:0]}, {1'b1, !holdAck, !holdAck, 2'h3});
    endtask : refuse
    // Main sequence
    initial begin
        seed = 37615;
        {nrst, cycleReq, haltSelect, cycleEnd, holdAck} = 5'h0;
        reqKind = KIND_NONE;
        {bus2.statusOe, bus2.selectOe, bus2.addrOneOut} = 3'h7;
        {bus2.codeIntackOut, bus2.memIoOut, bus2.statusHiOut, bus2.statusLoOut} = 4'hF;
        repeat (8) @(negedge core_clk);
        nrst = 1'b1;
        for (int i = 1; i < 8; i++) begin
            runCycle(cycle_kind_t'(i), 1'b1);
        end
        runCycle(KIND_HALT_SHUT, 1'b0);
        repeat (40) begin
            runCycle(cycle_kind_t'(1 + $unsigned($random(seed)) % 7), 1'($random(seed)));
        end
        refuse(KIND_NONE);
        refuse(KIND_RESERVED);
        holdAck = 1'b1;
        refuse(KIND_MEM_READ);
        holdAck = 1'b0;
        nrst = 1'b0;
        @(negedge core_clk);
        check({bus.statusOe, pins[1:0]}, 3'h3);
        nrst = 1'b1;
        runCycle(KIND_INTACK, 1'b0);
        // Every pin code into the bench-fed decoder
        for (int c = 0; c < 16; c++) begin
            logic [3:0] v;
            logic a, lg, hs;
            v = 4'(c);
            a = 1'($random(seed));
            lg = v inside {4'h0, 4'h4, 4'h5, 4'h6, 4'h9, 4'hA, 4'hD};
            hs = (v == 4'h4);
            {bus2.codeIntackOut, bus2.memIoOut, bus2.statusHiOut, bus2.statusLoOut} = v;
            bus2.addrOneOut = a;
            #1 check(inStart2, v[1:0] != 2'h3);
            @(negedge core_clk);
            check({start2, resv2, halt2, shut2}, {lg, !lg && v[1:0] != 2'h3, hs && a, hs && !a});
        end
        end_of_test();
    end
endmodule : bus_cycle_status_encoder_tb_top
